// ---- logic/i2c_seq_pkg.sv ----
// constants and types shared by the two-wire master sequence controller
package i2c_seq_pkg;

  // register byte offsets
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] STATUS_OFF = 8'h04;
  localparam logic [7:0] RXDATA_OFF = 8'h08;

  // bus_sequence_control field positions
  localparam int START_GO_BIT = 0;
  localparam int RESTART_GO_BIT = 1;
  localparam int STOP_GO_BIT = 2;
  localparam int RX_GO_BIT = 3;
  localparam int ACK_GO_BIT = 4;
  localparam int ACK_VAL_BIT = 5;
  localparam int GO_W = 5;
  localparam logic [5:0] CTRL_RESET = 6'h00;

  // status register field positions
  localparam int ST_RX_VALID = 0;
  localparam int ST_RX_FULL = 1;
  localparam int ST_BUSY = 2;
  localparam int ST_SCL = 3;
  localparam int ST_SDA = 4;

  // receive data register: byte in the low bits, valid flag above it
  localparam int RX_VALID_BIT = 8;

  // axi response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // timing: one serial clock period is split into four quarters
  localparam int SCL_PERIOD_NS = 10000;
  localparam int CLK_PERIOD_NS = 40;
  localparam int QTR_RAW = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
  localparam int QTR_CYCLES = (QTR_RAW < 2) ? 2 : QTR_RAW;

  // receive path
  localparam int BYTE_W = 8;
  localparam int RX_FIFO_DEPTH = 16;

  // bus sequences the controller can run
  typedef enum logic [2:0] {
    SEQ_IDLE,
    SEQ_START,
    SEQ_RESTART,
    SEQ_STOP,
    SEQ_RX,
    SEQ_ACK
  } seq_e;

endpackage

// ---- logic/i2c_master_sequence_control.sv ----
// two-wire master sequence controller with axi4-lite registers and receive fifo
//
// Notes on behaviour
// - during acknowledge the data line carries ack_value_select: 1 nack, 0 ack
// - writing 1 to ack_sequence_go starts an acknowledge clock on the clock line
// - ack_sequence_go reads 1 while running, hardware clears it at the end
// - master_receive_go clocks in one byte, cleared after the eighth bit
// - stop_condition_go makes a stop condition, cleared when it finishes
// - restart_condition_go makes a repeated start, cleared when it ends
// - start_condition_go makes a start condition, cleared at its end
//
// Added by the designer: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps

// fifo holding received bytes until software reads them
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  // elaboration check: pointer wrap logic needs at least two entries
  if (DEPTH < 2 || WIDTH < 1) begin : g_bad_shape
    $error("byte_fifo needs DEPTH >= 2 and WIDTH >= 1");
  end

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wptr;
    logic [AW-1:0] rptr;
    logic [AW:0] count;
  } fifo_s;

  fifo_s r;
  fifo_s n;
  logic push;
  logic pop;

  // handshakes are gated by ce so a frozen fifo never takes an item
  assign in_ready = ce && (r.count != (AW+1)'(DEPTH));
  assign out_valid = (r.count != '0);
  assign out_data = r.mem[r.rptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready && ce;

  // next state of pointers, count and storage
  always_comb begin
    n = r;
    if (push) begin
      n.mem[r.wptr] = in_data;
      n.wptr = (r.wptr == AW'(DEPTH - 1)) ? '0 : r.wptr + 1'b1;
    end
    if (pop) begin
      n.rptr = (r.rptr == AW'(DEPTH - 1)) ? '0 : r.rptr + 1'b1;
    end
    if (push && !pop) begin
      n.count = r.count + 1'b1;
    end else if (pop && !push) begin
      n.count = r.count - 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= '0;
    end else if (ce) begin
      r <= n;
    end
  end
endmodule

// sequence controller top: register slave, bus sequencer, line drivers
module i2c_master_sequence_control #(
  parameter int QTR = i2c_seq_pkg::QTR_CYCLES,
  parameter int FIFO_DEPTH = i2c_seq_pkg::RX_FIFO_DEPTH
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe
);
  // elaboration check: quarter counter is 16 bits and needs two states
  if (QTR < 2 || QTR > 65535) begin : g_bad_qtr
    $error("QTR must lie between 2 and 65535");
  end

  typedef struct packed {
    logic aw_held;
    logic [7:0] aw_addr;
    logic w_held;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic ack_value_select;
    logic [i2c_seq_pkg::GO_W-1:0] go;
    i2c_seq_pkg::seq_e seq;
    logic [1:0] qtr;
    logic [15:0] cnt;
    logic [2:0] bitn;
    logic [7:0] shift;
    logic scl_low;
    logic sda_low;
    logic scl_s1;
    logic scl_s2;
    logic sda_s1;
    logic sda_s2;
  } state_s;

  state_s r;
  state_s n;

  logic aw_take;
  logic w_take;
  logic ar_take;
  logic have_aw;
  logic have_w;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic adv;
  logic done;
  logic rx_push;
  logic rx_pop;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [7:0] fifo_out_data;

  // line levels per quarter, {scl_low, sda_low}
  function automatic logic [1:0] drive(input i2c_seq_pkg::seq_e s, input logic [1:0] q,
                                       input logic ackv);
    logic edge_q;
    edge_q = (q == 2'h0) || (q == 2'h3);
    case (s)
      i2c_seq_pkg::SEQ_START: drive = {q == 2'h3, q != 2'h0};
      i2c_seq_pkg::SEQ_RESTART: drive = {edge_q, q[1]};
      i2c_seq_pkg::SEQ_STOP: drive = {q == 2'h0, q != 2'h3};
      i2c_seq_pkg::SEQ_RX: drive = {edge_q, 1'b0};
      // a set select bit leaves data released, which the slave reads as nack
      i2c_seq_pkg::SEQ_ACK: drive = {edge_q, !ackv};
      default: drive = 2'h0;
    endcase
  endfunction

  // bus handshakes; ce low refuses everything so no item is lost while frozen
  assign s_axi_awready = ce && !r.aw_held && !r.bvalid;
  assign s_axi_wready = ce && !r.w_held && !r.bvalid;
  assign s_axi_arready = ce && !r.rvalid;
  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take = s_axi_wvalid && s_axi_wready;
  assign ar_take = s_axi_arvalid && s_axi_arready;
  assign have_aw = r.aw_held || aw_take;
  assign have_w = r.w_held || w_take;
  assign wr_addr = r.aw_held ? r.aw_addr : s_axi_awaddr;
  assign wr_data = r.w_held ? r.wdata : s_axi_wdata;
  assign wr_strb = r.w_held ? r.wstrb : s_axi_wstrb;

  // reading the receive data register pops one byte
  assign rx_pop = ar_take && ({s_axi_araddr[7:2], 2'h0} == i2c_seq_pkg::RXDATA_OFF);

  // quarter ends when its count expires; a released clock waits until seen high
  assign adv = (r.cnt == 16'(QTR - 1)) && (r.scl_low || r.scl_s2);
  assign done = (r.seq != i2c_seq_pkg::SEQ_IDLE) && adv && (r.qtr == 2'h3) &&
                ((r.seq != i2c_seq_pkg::SEQ_RX) || (r.bitn == 3'h7));
  assign rx_push = done && (r.seq == i2c_seq_pkg::SEQ_RX);

  byte_fifo #(
    .WIDTH(i2c_seq_pkg::BYTE_W),
    .DEPTH(FIFO_DEPTH)
  ) u_rx_fifo (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .in_valid(rx_push),
    .in_ready(fifo_in_ready),
    .in_data(r.shift),
    .out_valid(fifo_out_valid),
    .out_ready(rx_pop),
    .out_data(fifo_out_data)
  );

  // open drain lines: output level is always low, enable pulls the wire
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe = r.scl_low;
  assign sda_oe = r.sda_low;
  assign s_axi_bvalid = r.bvalid;
  assign s_axi_bresp = r.bresp;
  assign s_axi_rvalid = r.rvalid;
  assign s_axi_rdata = r.rdata;
  assign s_axi_rresp = r.rresp;

  always_comb begin
    n = r;

    // pin synchronisers, second stage is the only one read
    n.scl_s1 = scl_in;
    n.scl_s2 = r.scl_s1;
    n.sda_s1 = sda_in;
    n.sda_s2 = r.sda_s1;

    // sequencer: start one requested sequence from idle
    if (r.seq == i2c_seq_pkg::SEQ_IDLE) begin
      // fixed priority protects against software setting several bits at once
      if (r.go[i2c_seq_pkg::START_GO_BIT]) begin
        n.seq = i2c_seq_pkg::SEQ_START;
      end else if (r.go[i2c_seq_pkg::RESTART_GO_BIT]) begin
        n.seq = i2c_seq_pkg::SEQ_RESTART;
      end else if (r.go[i2c_seq_pkg::STOP_GO_BIT]) begin
        n.seq = i2c_seq_pkg::SEQ_STOP;
      end else if (r.go[i2c_seq_pkg::RX_GO_BIT] && fifo_in_ready) begin
        // a full fifo holds off the receive until software drains a byte
        n.seq = i2c_seq_pkg::SEQ_RX;
      end else if (r.go[i2c_seq_pkg::ACK_GO_BIT]) begin
        n.seq = i2c_seq_pkg::SEQ_ACK;
      end
      n.qtr = 2'h0;
      n.cnt = 16'h0000;
      n.bitn = 3'h0;
      if (n.seq != i2c_seq_pkg::SEQ_IDLE) begin
        {n.scl_low, n.sda_low} = drive(n.seq, 2'h0, r.ack_value_select);
      end
    end else if (done) begin
      // sequence over: hardware clears its go bit, bus clock stays low except after a stop, which leaves it released
      n.seq = i2c_seq_pkg::SEQ_IDLE;
      n.cnt = 16'h0000;
      case (r.seq)
        i2c_seq_pkg::SEQ_START: n.go[i2c_seq_pkg::START_GO_BIT] = 1'b0;
        i2c_seq_pkg::SEQ_RESTART: n.go[i2c_seq_pkg::RESTART_GO_BIT] = 1'b0;
        i2c_seq_pkg::SEQ_STOP: n.go[i2c_seq_pkg::STOP_GO_BIT] = 1'b0;
        i2c_seq_pkg::SEQ_RX: n.go[i2c_seq_pkg::RX_GO_BIT] = 1'b0;
        default: n.go[i2c_seq_pkg::ACK_GO_BIT] = 1'b0;
      endcase
      // data released only after the clock has been low for a quarter
      if (r.seq == i2c_seq_pkg::SEQ_ACK) begin
        n.sda_low = 1'b0;
      end
    end else if (adv) begin
      n.cnt = 16'h0000;
      // sample at the end of the high clock phase, just before the clock falls
      if (r.seq == i2c_seq_pkg::SEQ_RX && r.qtr == 2'h2) begin
        n.shift = {r.shift[6:0], r.sda_s2};
      end
      if (r.qtr == 2'h3) begin
        n.qtr = 2'h0;
        n.bitn = r.bitn + 3'h1;
      end else begin
        n.qtr = r.qtr + 2'h1;
      end
      {n.scl_low, n.sda_low} = drive(r.seq, n.qtr, r.ack_value_select);
    end else if (r.cnt != 16'(QTR - 1)) begin
      // count holds at its end while a slave stretches the clock
      n.cnt = r.cnt + 16'h0001;
    end

    // write channel: address and data taken in either order
    if (aw_take) begin
      n.aw_held = 1'b1;
      n.aw_addr = s_axi_awaddr;
    end
    if (w_take) begin
      n.w_held = 1'b1;
      n.wdata = s_axi_wdata;
      n.wstrb = s_axi_wstrb;
    end
    if (have_aw && have_w) begin
      n.aw_held = 1'b0;
      n.w_held = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = i2c_seq_pkg::RESP_OKAY;
      if ({wr_addr[7:2], 2'h0} == i2c_seq_pkg::CTRL_OFF) begin
        if (wr_strb[0]) begin
          n.ack_value_select = wr_data[i2c_seq_pkg::ACK_VAL_BIT];
          // a set arriving with the hardware clear wins; writing 0 is ignored
          n.go = n.go | wr_data[i2c_seq_pkg::GO_W-1:0];
        end
      end else if ({wr_addr[7:2], 2'h0} == i2c_seq_pkg::STATUS_OFF) begin
        n.bresp = i2c_seq_pkg::RESP_OKAY;
      end else if ({wr_addr[7:2], 2'h0} == i2c_seq_pkg::RXDATA_OFF) begin
        n.bresp = i2c_seq_pkg::RESP_OKAY;
      end else begin
        n.bresp = i2c_seq_pkg::RESP_SLVERR;
      end
    end
    if (r.bvalid && s_axi_bready) begin
      n.bvalid = 1'b0;
    end

    // read channel: one cycle answer, registered data
    if (ar_take) begin
      n.rvalid = 1'b1;
      n.rresp = i2c_seq_pkg::RESP_OKAY;
      n.rdata = 32'h0000_0000;
      if ({s_axi_araddr[7:2], 2'h0} == i2c_seq_pkg::CTRL_OFF) begin
        n.rdata[i2c_seq_pkg::ACK_VAL_BIT] = r.ack_value_select;
        n.rdata[i2c_seq_pkg::GO_W-1:0] = r.go;
      end else if ({s_axi_araddr[7:2], 2'h0} == i2c_seq_pkg::STATUS_OFF) begin
        n.rdata[i2c_seq_pkg::ST_RX_VALID] = fifo_out_valid;
        n.rdata[i2c_seq_pkg::ST_RX_FULL] = !fifo_in_ready;
        n.rdata[i2c_seq_pkg::ST_BUSY] = (r.seq != i2c_seq_pkg::SEQ_IDLE);
        n.rdata[i2c_seq_pkg::ST_SCL] = r.scl_s2;
        n.rdata[i2c_seq_pkg::ST_SDA] = r.sda_s2;
      end else if ({s_axi_araddr[7:2], 2'h0} == i2c_seq_pkg::RXDATA_OFF) begin
        n.rdata[i2c_seq_pkg::RX_VALID_BIT] = fifo_out_valid;
        n.rdata[7:0] = fifo_out_valid ? fifo_out_data : 8'h00;
      end else begin
        n.rresp = i2c_seq_pkg::RESP_SLVERR;
      end
    end else if (r.rvalid && s_axi_rready) begin
      n.rvalid = 1'b0;
    end
  end

  // single register of all state; ce low freezes everything
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= '0;
    end else if (ce) begin
      r <= n;
    end
  end
endmodule

// ---- tb/i2c_seq_assertions.sv ----
// protocol checker for the two-wire sequence controller
`timescale 1ns/1ps
module i2c_seq_checker #(parameter int QTR = 2) (
  input wire logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready,
  input wire logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_rvalid, s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic scl_in, scl_oe, sda_oe
);
  // slack of a few cycles covers the line synchronisers
  localparam int Q3 = 3 * QTR + 4;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // data pulled while the clock is released is a start, clock must follow
  sequence s_data_falls; $rose(sda_oe) && !scl_oe; endsequence
  sequence s_clock_pulled; ##[1:Q3] scl_oe; endsequence
  property p_start; s_data_falls |-> s_clock_pulled; endproperty
  a_start: assert property (p_start) else $error("clock not pulled after start");
  property p_stop; $fell(sda_oe) && !scl_oe |=> (!scl_oe && !sda_oe) [*4]; endproperty
  a_stop: assert property (p_stop) else $error("lines driven after stop");
  // a slave holding the clock low must keep the quarter from ending
  property p_stretch; (!scl_oe && !scl_in) [*3] |=> !scl_oe; endproperty
  a_stretch: assert property (p_stretch) else $error("clock stretch ignored");
  property p_wr_resp;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid;
  endproperty
  a_wr_resp: assert property (p_wr_resp) else $error("write response late");
  property p_b_drop; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
  a_b_drop: assert property (p_b_drop) else $error("write response repeated");
  property p_rd_lat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read data late");
  property p_r_drop; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
  a_r_drop: assert property (p_r_drop) else $error("read data repeated");
  property p_unmapped;
    s_axi_arvalid && s_axi_arready && (s_axi_araddr[7:4] != 4'h0)
      |=> s_axi_rresp == i2c_seq_pkg::RESP_SLVERR && s_axi_rdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
endmodule
bind i2c_master_sequence_control i2c_seq_checker #(.QTR(QTR)) i_i2c_seq_checker (.*);

// ---- tb/i2c_slave_model.sv ----
// behavioural two-wire slave: sends armed bytes, records ack, counts conditions
`timescale 1ns/1ps
module i2c_slave_model (
  input wire logic scl_wire,
  input wire logic sda_wire,
  output logic scl_pull,
  output logic sda_pull
);
  logic [7:0] shift_reg = 8'h00;
  logic ack_bit = 1'b0;
  int bit_cnt = 8;
  int stretch_ns = 0;
  int starts = 0;
  int stops = 0;
  initial scl_pull = 1'b0;
  // msb first while a byte is armed, released otherwise so the pull-up wins
  assign sda_pull = (bit_cnt < 8) && !shift_reg[7];
  task automatic arm(input logic [7:0] b, input int st);
    shift_reg = b;
    bit_cnt = 0;
    stretch_ns = st;
  endtask
  // data changing with the clock high marks start, repeated start or stop
  always @(negedge sda_wire) if (scl_wire === 1'b1) starts++;
  always @(posedge sda_wire) if (scl_wire === 1'b1) stops++;
  // next bit after each falling clock; optional stretch makes the slave slow
  always @(negedge scl_wire) begin
    if (bit_cnt < 8) begin
      shift_reg <= shift_reg << 1;
      bit_cnt <= bit_cnt + 1;
    end
    if (stretch_ns > 0) begin
      scl_pull = 1'b1;
      #(stretch_ns);
      scl_pull = 1'b0;
    end
  end
  // ninth clock carries the master's acknowledge
  always @(posedge scl_wire) if (bit_cnt == 8) ack_bit = sda_wire;
endmodule

// ---- tb/i2c_master_sequence_control_tb.sv ----
// self-checking bench for the two-wire sequence controller
`timescale 1ns/1ps
module i2c_master_sequence_control_tb;
  localparam int QTR = 2;
  logic aclk = 1'b0, aresetn = 1'b0, ce = 1'b1, s_axi_bready = 1'b1, s_axi_rready = 1'b1;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb = 4'h1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic scl_in, scl_out, scl_oe, sda_in, sda_out, sda_oe, scl_pull, sda_pull, v;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [7:0] b, exp_q[$];
  int error_cnt = 0, checks = 0, n;
  // open-drain lines with pull-ups
  assign scl_in = !(scl_oe || scl_pull);
  assign sda_in = !(sda_oe || sda_pull);
  i2c_master_sequence_control #(.QTR(QTR), .FIFO_DEPTH(16)) i_i2c_master_sequence_control (.*);
  i2c_slave_model i_i2c_slave_model (.scl_wire(scl_in), .sda_wire(sda_in),
    .scl_pull(scl_pull), .sda_pull(sda_pull));
  always #20 aclk = ~aclk;
  function automatic logic [31:0] rx_word(input logic [7:0] x);
    return {23'h0, 1'b1, x};
  endfunction
  function automatic logic [31:0] ctrl_word(input logic x);
    return {26'h0, x, 5'h0};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // readiness is sampled at the falling edge so the rising edge sees no race
  task automatic wr(input logic [7:0] a, input logic [31:0] x, input logic [1:0] er);
    logic aw, w, bv;
    logic [1:0] resp;
    s_axi_awaddr <= a;
    s_axi_wdata <= x;
    s_axi_wstrb <= 4'h1 | 4'($urandom);
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(negedge aclk);
      aw = s_axi_awvalid && s_axi_awready;
      w = s_axi_wvalid && s_axi_wready;
      bv = s_axi_bvalid;
      resp = s_axi_bresp;
      @(posedge aclk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
    end while (!bv);
    chk(32'(resp), 32'(er));
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] x, output logic [1:0] rr);
    logic ar, rv;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(negedge aclk);
      ar = s_axi_arvalid && s_axi_arready;
      rv = s_axi_rvalid;
      x = s_axi_rdata;
      rr = s_axi_rresp;
      @(posedge aclk);
      if (ar) s_axi_arvalid <= 1'b0;
    end while (!rv);
  endtask
  // request a sequence, see its go bit set, then poll until hardware clears it
  task automatic go(input logic [31:0] x, input int bit_no);
    logic [31:0] q;
    logic [1:0] qr;
    wr(8'h00, x, i2c_seq_pkg::RESP_OKAY);
    rd(8'h00, q, qr);
    chk(32'(q[bit_no]), 32'h1);
    do rd(8'h00, q, qr); while (q[bit_no] === 1'b1);
  endtask
  task automatic final_report;
    $display("checks=%0d error_cnt=%0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // main sequence: registers, start, fifo fill with acks, drain, restart, stop
  initial begin
    void'($urandom(32'h6392));
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(8'h00, d, r);
    chk(d, 32'h0);
    rd(8'h40, d, r);
    chk(32'(r), 32'(i2c_seq_pkg::RESP_SLVERR));
    wr(8'h0c, 32'h3f, i2c_seq_pkg::RESP_SLVERR);
    wr(8'h04, 32'hffff_ffff, i2c_seq_pkg::RESP_OKAY);
    n = i_i2c_slave_model.starts;
    go(32'h01, 0);
    chk(32'(i_i2c_slave_model.starts), 32'(n + 1));
    for (int i = 0; i < 17; i++) begin
      b = 8'($urandom);
      exp_q.push_back(b);
      i_i2c_slave_model.arm(b, ($urandom % 2) * 400);
      if (i < 16) begin
        go(32'h08, 3);
        v = 1'($urandom);
        go(ctrl_word(v) | 32'h10, 4);
        chk(32'(i_i2c_slave_model.ack_bit), 32'(v));
        rd(8'h00, d, r);
        chk(d, ctrl_word(v));
      end
    end
    // fifo now full: a further receive must wait with its go bit up
    rd(8'h04, d, r);
    chk(32'(d[1:0]), 32'h3);
    wr(8'h00, 32'h08, i2c_seq_pkg::RESP_OKAY);
    repeat (40) @(posedge aclk);
    rd(8'h00, d, r);
    chk(32'(d[3]), 32'h1);
    for (int i = 0; i < 16; i++) begin
      rd(8'h08, d, r);
      chk(d, rx_word(exp_q.pop_front()));
    end
    do rd(8'h00, d, r); while (d[3] === 1'b1);
    rd(8'h08, d, r);
    chk(d, rx_word(exp_q.pop_front()));
    rd(8'h08, d, r);
    chk(d, 32'h0);
    n = i_i2c_slave_model.starts;
    go(32'h02, 1);
    chk(32'(i_i2c_slave_model.starts), 32'(n + 1));
    n = i_i2c_slave_model.stops;
    go(32'h04, 2);
    chk(32'(i_i2c_slave_model.stops), 32'(n + 1));
    chk(32'({scl_out, sda_out}), 32'h0);
    final_report;
  end
  // watchdog well beyond the few thousand cycles the sequence needs
  initial begin
    repeat (20000) @(posedge aclk);
    error_cnt++;
    final_report;
  end
endmodule
